// *** synth_serial_register_bank.sv ***
`timescale 1ns/100ps
`default_nettype none
// Function
// - Select code 000 writes latch zero, holding integer and fraction.
// - Select code 001 writes latch one, holding prescaler, phase, modulus.
// - Integer divide value is word bits 30 to 15.
// - Fraction numerator is word bits 14 to 3.
// - Integer and fraction from latch zero together pick the channel.
// - Double-buffered fields wait for the next latch-zero write.
// - Divider select of latch four waits only while latch two bit 13 is set.
// - Data shifts in on rising serial clock, MSB first, 32 bits.
// - Rising latch strobe copies the word into the selected latch.
// - Latch one bit 27 chooses the 4/5 or 8/9 prescaler.
module synth_serial_register_bank (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        sclk_i,
  input  wire logic        sdata_i,
  input  wire logic        latch_strobe_i,
  output logic [15:0]      int_value_o,
  output logic [11:0]      fraction_numerator_o,
  output logic             prescaler_ratio_select_o,
  output logic [11:0]      phase_value_o,
  output logic [11:0]      fractional_modulus_o,
  output logic [31:0]      ref_pump_word_o,
  output logic [31:0]      clk_div_word_o,
  output logic [31:0]      out_stage_word_o,
  output logic [31:0]      lock_pin_word_o,
  output logic             channel_update_o
);
  // Shift register and strobe capture run on the link pins
  serial_word_if wlink ();

  logic        take;
  logic [31:0] word;

  serial_shifter u_shift (
    .sclk_i         (sclk_i),
    .sdata_i        (sdata_i),
    .latch_strobe_i (latch_strobe_i),
    .wout           (wlink.src)
  );

  // The strobe event crosses into clk_i here; the word is
  // stable long before the synchronised event arrives
  word_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .win    (wlink.dst),
    .take_o (take),
    .word_o (word)
  );

  // Latches as written, and values in effect
  logic [31:0] lat_q [synth_regs_pkg::NUM_LAT];
  logic [31:0] act1_q;
  logic [31:0] act2_q;
  logic [31:0] act4_q;
  logic        upd_q;
  logic        wr0;
  logic        unused_code;
  logic        dbuf_en;

  // Select decode, shared by every latch and several checks
  function automatic logic hit(input logic [31:0] w,
                               input logic [2:0]  s);
    hit = (w[synth_regs_pkg::SEL_W-1:0] == s);
  endfunction

  // Masked bits keep the held value, the rest follow the latch
  function automatic logic [31:0] blend(input logic [31:0] held,
                                        input logic [31:0] live,
                                        input logic [31:0] mask);
    blend = (held & mask) | (live & ~mask);
  endfunction

  assign wr0 = take && hit(word, synth_regs_pkg::SEL_INT_FRACTION_NUMERATOR);

  assign unused_code = take
      && (word[2:0] > synth_regs_pkg::SEL_LOCK_PIN);

  // Taken from the latch as written: the enable itself is not buffered
  assign dbuf_en = lat_q[2][synth_regs_pkg::DBUF_EN_BIT];

  // One latch per select code; codes 110 and 111 match none
  genvar gi;
  generate
    for (gi = 0; gi < synth_regs_pkg::NUM_LAT; gi++) begin : g_lat
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          lat_q[gi] <= synth_regs_pkg::WORD_ZERO;
        end else if (take && hit(word, 3'(gi))) begin
          lat_q[gi] <= word;
        end
      end
    end
  endgenerate

  // Latch one: prescaler live, phase and modulus wait for latch zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act1_q <= synth_regs_pkg::WORD_ZERO;
    end else if (wr0) begin
      act1_q <= lat_q[1];
    end else begin
      act1_q <= blend(act1_q, lat_q[1], synth_regs_pkg::DBR_MASK_1);
    end
  end

  // Latch two: reference and pump fields wait for latch zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act2_q <= synth_regs_pkg::WORD_ZERO;
    end else if (wr0) begin
      act2_q <= lat_q[2];
    end else begin
      act2_q <= blend(act2_q, lat_q[2], synth_regs_pkg::DBR_MASK_2);
    end
  end

  // Divider select buffered only while latch two asks for it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act4_q <= synth_regs_pkg::WORD_ZERO;
    end else if (wr0 || !dbuf_en) begin
      act4_q <= lat_q[4];
    end else begin
      act4_q <= blend(act4_q, lat_q[4], synth_regs_pkg::DBB_MASK_4);
    end
  end

  // Marks the cycle in which a new channel is in effect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= wr0;
    end
  end

  // Outputs are flops already; channel pair read from latch zero
  assign int_value_o =
      lat_q[0][synth_regs_pkg::INT_MSB:synth_regs_pkg::INT_LSB];
  assign fraction_numerator_o =
      lat_q[0][synth_regs_pkg::FRACTION_NUMERATOR_MSB:synth_regs_pkg::FRACTION_NUMERATOR_LSB];
  assign prescaler_ratio_select_o =
      act1_q[synth_regs_pkg::PRESC_BIT];
  assign phase_value_o =
      act1_q[synth_regs_pkg::PHASE_MSB:synth_regs_pkg::PHASE_LSB];
  assign fractional_modulus_o =
      act1_q[synth_regs_pkg::MOD_MSB:synth_regs_pkg::MOD_LSB];
  assign ref_pump_word_o      = act2_q;
  assign clk_div_word_o       = lat_q[3];
  assign out_stage_word_o     = act4_q;
  assign lock_pin_word_o      = lat_q[5];
  assign channel_update_o     = upd_q;

  a_zero_write_applies: assert property (@(posedge clk_i) disable iff (rst_i)
    wr0 |=> (act1_q == $past(lat_q[1])) && upd_q)
    else $error("buffered latch one not applied on latch zero write");

  a_div_immediate: assert property (@(posedge clk_i) disable iff (rst_i)
    !dbuf_en |=> act4_q == $past(lat_q[4]))
    else $error("divider select not immediate");

  a_div_held: assert property (@(posedge clk_i) disable iff (rst_i)
    (dbuf_en && !wr0) |=>
      act4_q[synth_regs_pkg::DIV_MSB:synth_regs_pkg::DIV_LSB]
      == $past(act4_q[synth_regs_pkg::DIV_MSB:synth_regs_pkg::DIV_LSB]))
    else $error("divider select changed without latch zero write");

  a_latch_one_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr0 |=> act1_q[synth_regs_pkg::MOD_MSB:synth_regs_pkg::MOD_LSB]
      == $past(act1_q[synth_regs_pkg::MOD_MSB:synth_regs_pkg::MOD_LSB]))
    else $error("modulus changed without latch zero write");

  a_latch_select: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && hit(word, synth_regs_pkg::SEL_PRE_MOD))
      |=> lat_q[1] == $past(word))
    else $error("latch one not written");

  a_zero_fields: assert property (@(posedge clk_i) disable iff (rst_i)
    wr0 |=> int_value_o
      == $past(word[synth_regs_pkg::INT_MSB:synth_regs_pkg::INT_LSB])
      && fraction_numerator_o
      == $past(word[synth_regs_pkg::FRACTION_NUMERATOR_MSB:synth_regs_pkg::FRACTION_NUMERATOR_LSB]))
    else $error("latch zero fields wrong");

  a_unused_code: assert property (@(posedge clk_i) disable iff (rst_i)
    unused_code |=> lat_q[0] == $past(lat_q[0])
      && lat_q[5] == $past(lat_q[5]))
    else $error("unused select code wrote a latch");

  a_unused_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    unused_code |=> lat_q[1] == $past(lat_q[1])
      && lat_q[2] == $past(lat_q[2])
      && lat_q[3] == $past(lat_q[3])
      && lat_q[4] == $past(lat_q[4]))
    else $error("unused select code wrote a middle latch");

  a_prescaler: assert property (@(posedge clk_i) disable iff (rst_i)
    wr0 |=> prescaler_ratio_select_o
      == $past(lat_q[1][synth_regs_pkg::PRESC_BIT]))
    else $error("prescaler select not applied");

  a_presc_live: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr0 |=> prescaler_ratio_select_o
      == $past(lat_q[1][synth_regs_pkg::PRESC_BIT]))
    else $error("prescaler select did not follow its latch");

  a_ref_buffer: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr0 |=> act2_q[synth_regs_pkg::RCNT_MSB:synth_regs_pkg::RCNT_LSB]
      == $past(act2_q[synth_regs_pkg::RCNT_MSB:synth_regs_pkg::RCNT_LSB]))
    else $error("reference counter changed without latch zero write");

  a_pump_buffer: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr0 |=> act2_q[synth_regs_pkg::CP_MSB:synth_regs_pkg::CP_LSB]
      == $past(act2_q[synth_regs_pkg::CP_MSB:synth_regs_pkg::CP_LSB]))
    else $error("pump setting changed without latch zero write");

  a_ref_ctrl_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr0 |=> act2_q[synth_regs_pkg::DBL_BIT]
      == $past(act2_q[synth_regs_pkg::DBL_BIT])
      && act2_q[synth_regs_pkg::RDIV2_BIT]
      == $past(act2_q[synth_regs_pkg::RDIV2_BIT]))
    else $error("doubler or divide by two changed early");

  a_phase_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr0 |=> act1_q[synth_regs_pkg::PHASE_MSB:synth_regs_pkg::PHASE_LSB]
      == $past(act1_q[synth_regs_pkg::PHASE_MSB:synth_regs_pkg::PHASE_LSB]))
    else $error("phase changed without latch zero write");

  a_live_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (act1_q & ~synth_regs_pkg::DBR_MASK_1)
      == ($past(lat_q[1]) & ~synth_regs_pkg::DBR_MASK_1))
    else $error("unbuffered latch one bits did not follow");

  a_live_two: assert property (@(posedge clk_i) disable iff (rst_i)
    (act2_q & ~synth_regs_pkg::DBR_MASK_2)
      == ($past(lat_q[2]) & ~synth_regs_pkg::DBR_MASK_2))
    else $error("unbuffered latch two bits did not follow");

  a_live_four: assert property (@(posedge clk_i) disable iff (rst_i)
    (act4_q & ~synth_regs_pkg::DBB_MASK_4)
      == ($past(lat_q[4]) & ~synth_regs_pkg::DBB_MASK_4))
    else $error("unbuffered latch four bits did not follow");

  a_ref_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && hit(word, synth_regs_pkg::SEL_REF_PUMP))
      |=> lat_q[2] == $past(word))
    else $error("latch two not written");

  a_clk_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && hit(word, synth_regs_pkg::SEL_CLK_DIV))
      |=> clk_div_word_o == $past(word))
    else $error("latch three not written");

  a_out_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && hit(word, synth_regs_pkg::SEL_OUT_STAGE))
      |=> lat_q[4] == $past(word))
    else $error("latch four not written");

  a_lock_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && hit(word, synth_regs_pkg::SEL_LOCK_PIN))
      |=> lock_pin_word_o == $past(word))
    else $error("latch five not written");

  a_single_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !hit(word, synth_regs_pkg::SEL_PRE_MOD))
      |=> lat_q[1] == $past(lat_q[1]))
    else $error("latch one written by another select code");

  a_zero_stands: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr0 |=> lat_q[0] == $past(lat_q[0]))
    else $error("latch zero changed without its select code");

  a_take_single: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> !take)
    else $error("strobe event taken twice");

  a_update_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr0 |=> !upd_q)
    else $error("channel update without latch zero write");

endmodule
`default_nettype wire

// *** synth_regs_pkg.sv ***
package synth_regs_pkg;

  localparam int unsigned WORD_W   = 32;
  localparam int unsigned SEL_W    = 3;
  localparam int unsigned NUM_LAT  = 6;
  localparam int unsigned CNT_W    = 5;

  // Latch select codes
  localparam logic [2:0] SEL_INT_FRACTION_NUMERATOR  = 3'h0;
  localparam logic [2:0] SEL_PRE_MOD   = 3'h1;
  localparam logic [2:0] SEL_REF_PUMP  = 3'h2;
  localparam logic [2:0] SEL_CLK_DIV   = 3'h3;
  localparam logic [2:0] SEL_OUT_STAGE = 3'h4;
  localparam logic [2:0] SEL_LOCK_PIN  = 3'h5;

  // Latch zero fields
  localparam int unsigned INT_MSB  = 30;
  localparam int unsigned INT_LSB  = 15;
  localparam int unsigned FRACTION_NUMERATOR_MSB = 14;
  localparam int unsigned FRACTION_NUMERATOR_LSB = 3;
  localparam int unsigned INT_W    = 16;
  localparam int unsigned FRACTION_NUMERATOR_W   = 12;

  // Latch one fields
  localparam int unsigned PRESC_BIT  = 27;
  localparam int unsigned PHASE_MSB  = 26;
  localparam int unsigned PHASE_LSB  = 15;
  localparam int unsigned MOD_MSB    = 14;
  localparam int unsigned MOD_LSB    = 3;

  // Latch two fields
  localparam int unsigned DBL_BIT     = 25;
  localparam int unsigned RDIV2_BIT   = 24;
  localparam int unsigned RCNT_MSB    = 23;
  localparam int unsigned RCNT_LSB    = 14;
  localparam int unsigned DBUF_EN_BIT = 13;
  localparam int unsigned CP_MSB      = 11;
  localparam int unsigned CP_LSB      = 9;

  // Latch four divider select field
  localparam int unsigned DIV_MSB = 22;
  localparam int unsigned DIV_LSB = 20;

  // Double-buffered bits of latches one, two and four
  localparam logic [31:0] DBR_MASK_1 = 32'h07FF_FFF8;
  localparam logic [31:0] DBR_MASK_2 = 32'h03FF_CE00;
  localparam logic [31:0] DBB_MASK_4 = 32'h0070_0000;

  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// *** serial_word_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface serial_word_if;
  logic [31:0] word;
  logic        toggle;
  modport src (output word, output toggle);
  modport dst (input word, input toggle);
endinterface
`default_nettype wire

// *** serial_shifter.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_shifter (
  input  wire logic   sclk_i,
  input  wire logic   sdata_i,
  input  wire logic   latch_strobe_i,
  serial_word_if.src  wout
);
  logic [31:0] shift_q;
  logic [31:0] word_q;
  // No reset reaches the link domain; power-up value set here
  logic        toggle_q = 1'b0;

  // MSB first, LSB ends in bit 0
  always_ff @(posedge sclk_i) begin
    shift_q <= {shift_q[30:0], sdata_i};
  end

  // Strobe is its own clock; toggle carries the event across
  always_ff @(posedge latch_strobe_i) begin
    word_q   <= shift_q;
    toggle_q <= ~toggle_q;
  end

  assign wout.word   = word_q;
  assign wout.toggle = toggle_q;
endmodule
`default_nettype wire

// *** word_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module word_sync (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  serial_word_if.dst       win,
  output logic             take_o,
  output logic [31:0]      word_o
);
  logic [2:0] tog_q;

  // Two stages then edge detect on stages two and three.
  // Not reset: clearing them while the toggle is high would fake an edge.
  // Needs three reset cycles at power up to fill the stages
  always_ff @(posedge clk_i) begin
    tog_q <= {tog_q[1:0], win.toggle};
  end

  // Word changes with the toggle and is stable for many cycles after it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      take_o <= 1'b0;
      word_o <= synth_regs_pkg::WORD_ZERO;
    end else begin
      take_o <= tog_q[2] ^ tog_q[1];
      if (tog_q[2] ^ tog_q[1]) begin
        word_o <= win.word;
      end
    end
  end
endmodule
`default_nettype wire

// *** host_serial_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
  output logic sclk_o,
  output logic sdata_o,
  output logic strobe_o
);
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    strobe_o = 1'b0;
  end
  // Caller supplies in-range values and mapped reserved bits
  task automatic send(input logic [31:0] w);
    #3;
    for (int i = 31; i >= 0; i--) begin
      sdata_o = w[i];
      #15 sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
    end
    #7 strobe_o = 1'b1;
    // Released line shows the inverse, not a stale bit
    sdata_o = ~w[0];
    #60 strobe_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** synth_serial_register_bank_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module synth_serial_register_bank_tb;
  typedef struct packed {
    logic [31:0] word;
    logic [15:0] int_v;
    logic [11:0] fraction_numerator;
    logic        presc;
    logic [11:0] modu;
  } row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  wire         sclk;
  wire         sdata;
  wire         strobe;
  logic [15:0] int_v;
  logic [11:0] fraction_numerator;
  logic        presc;
  logic [11:0] phase;
  logic [11:0] modu;
  logic [31:0] ref_w;
  logic [31:0] clk_w;
  logic [31:0] out_w;
  logic [31:0] lock_w;
  logic        upd;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          n_upd = 0;
  int          u0;
  row_t        rows [5] = '{
    '{32'h0800_83E9, 16'h0000, 12'h000, 1'b1, 12'h000},
    '{32'h0032_0038, 16'h0064, 12'h007, 1'b1, 12'h07D},
    '{32'h7FFF_83E0, 16'hFFFF, 12'h07C, 1'b1, 12'h07D},
    '{32'hFFFF_FFFE, 16'hFFFF, 12'h07C, 1'b1, 12'h07D},
    '{32'hFFFF_FFFF, 16'hFFFF, 12'h07C, 1'b1, 12'h07D}};

  always #5 clk_i = ~clk_i;

  host_serial_model host (.sclk_o(sclk), .sdata_o(sdata), .strobe_o(strobe));

  synth_serial_register_bank uut (
    .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .sdata_i(sdata),
    .latch_strobe_i(strobe), .int_value_o(int_v),
    .fraction_numerator_o(fraction_numerator), .prescaler_ratio_select_o(presc),
    .phase_value_o(phase), .fractional_modulus_o(modu),
    .ref_pump_word_o(ref_w), .clk_div_word_o(clk_w),
    .out_stage_word_o(out_w), .lock_pin_word_o(lock_w),
    .channel_update_o(upd));

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] w);
    host.send(w);
    repeat (8) @(posedge clk_i);
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Run takes about 1500 cycles; ceiling leaves margin
  always @(posedge clk_i) begin
    cycles++;
    if (upd === 1'b1)
      n_upd++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("int reset", int_v, 32'h0);
    chk("mod reset", modu, 32'h0);
    for (int i = 0; i < 5; i++) begin
      u0 = n_upd;
      wr(rows[i].word);
      chk("int", int_v, rows[i].int_v);
      chk("fraction_numerator", fraction_numerator, rows[i].fraction_numerator);
      chk("presc", presc, rows[i].presc);
      chk("mod", modu, rows[i].modu);
      chk("update", n_upd - u0, rows[i].word[2:0] == 3'h0);
    end
    chk("phase", phase, 12'h001);
    wr(32'h0000_2E42);
    chk("dbuf bit", ref_w[13], 1'b1);
    chk("pump held", ref_w[11:9], 3'h0);
    wr(32'h0050_0004);
    chk("div held", out_w[22:20], 3'h0);
    wr(32'h0032_0038);
    chk("pump applied", ref_w[11:9], 3'h7);
    chk("div applied", out_w[22:20], 3'h5);
    wr(32'h0000_0E42);
    wr(32'h0020_0004);
    chk("div direct", out_w[22:20], 3'h2);
    wr(32'h0000_0123);
    chk("latch3", clk_w[14:3], 12'h024);
    wr(32'h1040_0005);
    chk("latch5", lock_w[31:3], 29'h0208_0000);
    // Odd write count leaves the strobe toggle high across reset
    wr(32'h1000_0005);
    chk("latch5 b", lock_w[31:3], 29'h0200_0000);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("int rerst", int_v, 32'h0);
    chk("out rerst", out_w, 32'h0);
    chk("lock rerst", lock_w, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
